/* logic/tasw_cfg.svh */
`ifndef TASW_CFG_SVH
`define TASW_CFG_SVH

// Register word offsets, byte addresses on the bus
`define TASW_OFS_TX_CFG 8'h00
`define TASW_OFS_HS_MODE 8'h04
`define TASW_OFS_AUX_MODE 8'h08
`define TASW_OFS_STATUS 8'h0C

// Transmit settings fields
`define TASW_TX_TERM_BIT 0
`define TASW_TX_CUR_BIT 1
`define TASW_TX_BOOST_LO 2
`define TASW_TX_BOOST_HI 3

// High speed mode fields
`define TASW_HS_ON_BIT 0
`define TASW_HS_MODE_LO 1
`define TASW_HS_MODE_HI 2
`define TASW_HS_SEL_LO 4
`define TASW_HS_SEL_HI 7

// Auxiliary mode fields
`define TASW_AUX_MODE_LO 0
`define TASW_AUX_MODE_HI 1
`define TASW_AUX_SEL_LO 4
`define TASW_AUX_SEL_HI 7

// Status fields
`define TASW_ST_SERIAL_BIT 0
`define TASW_ST_TERM_BIT 1
`define TASW_ST_CUR_BIT 2
`define TASW_ST_EN_BIT 3
`define TASW_ST_BOOST_LO 4
`define TASW_ST_BOOST_HI 5

// Reset values of the serial settings
`define TASW_RST_EN 1'h1
`define TASW_RST_BOOST 2'h0
`define TASW_RST_SEL 4'h0

`endif

/* logic/tasw_pkg.sv */
package tasw_pkg;

    // Routing modes of the channel and auxiliary switches
    typedef enum logic [1:0] {
        TASW_QUAD = 2'h0,
        TASW_DUAL = 2'h1,
        TASW_SINGLE = 2'h2
    } tasw_mode_t;

    // Input channel index chosen for each of the four outputs
    typedef struct packed {
        logic [3:0] ch3;
        logic [3:0] ch2;
        logic [3:0] ch1;
        logic [3:0] ch0;
    } tasw_route_t;

    // Settings of the high speed output drivers
    typedef struct packed {
        logic term_on;
        logic enable;
        logic current_hi;
        logic [1:0] boost;
    } tasw_drive_t;

endpackage

/* logic/tasw_ctrl.sv */
// Contract
// - Output termination follows serial bit or pin.
// - Disabled outputs go tristate, serial or pin.
// - Termination taken from its pin after reset.
// - Current level taken from its pin after reset.
// - Four boost levels from serial field or pins.
// - Three channel routing modes, serial field only.
// - Quad mode routes one four-channel group.
// - Dual and single modes only under serial control.
// - Dual mode: two locked 8:1 switches.
// - Single mode: one of 16 to all.
// - Three auxiliary modes, independent, serial only.
// - Parallel auxiliary routing is quad, shared select.
// - Auxiliary quad mode routes one four-line group.
// - Auxiliary dual mode: two locked 8:1 switches.
// - Auxiliary single mode: one of 16 to all.
// - Any serial access locks out pins until reset.
// - Parallel select switches channels and auxiliary together.
`include "tasw_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module tasw_ctrl (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Parallel control pins
    input wire logic par_out_term_pin_i,
    input wire logic par_out_enable_pin_i,
    input wire logic par_current_level_pin_i,
    input wire logic [1:0] par_boost_bus_i,
    input wire logic [1:0] par_channel_select_bus_i,
    // Switch and driver controls
    output var tasw_pkg::tasw_drive_t drive_o,
    output var tasw_pkg::tasw_route_t hs_route_o,
    output var tasw_pkg::tasw_route_t aux_route_o,
    output logic serial_o
);

    // Decode a mode and select code into per-output input indices
    function automatic tasw_pkg::tasw_route_t route_of(
        input tasw_pkg::tasw_mode_t mode,
        input logic [3:0] sel
    );
        tasw_pkg::tasw_route_t r;
        r = '0;
        case (mode)
            // Two locked switches, each picks one channel of a pair
            tasw_pkg::TASW_DUAL: begin
                r.ch0 = {sel[2:0], 1'h0};
                r.ch1 = {sel[2:0], 1'h0};
                r.ch2 = {sel[2:0], 1'h1};
                r.ch3 = {sel[2:0], 1'h1};
            end
            // One channel out of sixteen to every output
            tasw_pkg::TASW_SINGLE: begin
                r.ch0 = sel;
                r.ch1 = sel;
                r.ch2 = sel;
                r.ch3 = sel;
            end
            // Quad, also the answer to the reserved code
            default: begin
                r.ch0 = {sel[1:0], 2'h0};
                r.ch1 = {sel[1:0], 2'h1};
                r.ch2 = {sel[1:0], 2'h2};
                r.ch3 = {sel[1:0], 2'h3};
            end
        endcase
        return r;
    endfunction

    // Bus handshake state
    logic wb_ack_ff; // Acknowledge, one cycle long
    logic [31:0] wb_dat_ff; // Read data held with the acknowledge
    logic nxt_wb_ack;
    logic [31:0] nxt_wb_dat;
    logic req; // Request present this cycle
    logic wr_take; // Write takes effect at this edge

    // Serial settings
    logic serial_ff; // Serial control has taken over
    logic strap_done_ff; // Pin levels already captured after reset
    logic ser_term_ff; // Internal termination on
    logic ser_cur_ff; // High current level
    logic [1:0] ser_boost_ff; // Pre-emphasis level
    logic ser_en_ff; // Outputs enabled
    tasw_pkg::tasw_mode_t ser_hs_mode_ff; // Channel routing mode
    logic [3:0] ser_hs_sel_ff; // Channel select code
    tasw_pkg::tasw_mode_t ser_aux_mode_ff; // Auxiliary routing mode
    logic [3:0] ser_aux_sel_ff; // Auxiliary select code
    logic nxt_serial;
    logic nxt_strap_done;
    logic nxt_ser_term;
    logic nxt_ser_cur;
    logic [1:0] nxt_ser_boost;
    logic nxt_ser_en;
    tasw_pkg::tasw_mode_t nxt_ser_hs_mode;
    logic [3:0] nxt_ser_hs_sel;
    tasw_pkg::tasw_mode_t nxt_ser_aux_mode;
    logic [3:0] nxt_ser_aux_sel;

    // Output state
    tasw_pkg::tasw_drive_t drive_ff;
    tasw_pkg::tasw_route_t hs_route_ff;
    tasw_pkg::tasw_route_t aux_route_ff;
    tasw_pkg::tasw_drive_t nxt_drive;
    tasw_pkg::tasw_route_t nxt_hs_route;
    tasw_pkg::tasw_route_t nxt_aux_route;

    assign req = wb_cyc_i && wb_stb_i;
    assign wr_take = req && wb_we_i && wb_ack_ff && wb_sel_i[0];

    // Bus answer: ack one cycle after the request, then dropped
    always_comb begin
        nxt_wb_ack = req && !wb_ack_ff;
        nxt_wb_dat = wb_dat_ff;
        if (req && !wb_ack_ff) begin
            nxt_wb_dat = 32'h0;
            if (wb_adr_i == `TASW_OFS_TX_CFG) begin
                nxt_wb_dat[`TASW_TX_TERM_BIT] = ser_term_ff;
                nxt_wb_dat[`TASW_TX_CUR_BIT] = ser_cur_ff;
                nxt_wb_dat[`TASW_TX_BOOST_HI:`TASW_TX_BOOST_LO] =
                    ser_boost_ff;
            end else if (wb_adr_i == `TASW_OFS_HS_MODE) begin
                nxt_wb_dat[`TASW_HS_ON_BIT] = ser_en_ff;
                nxt_wb_dat[`TASW_HS_MODE_HI:`TASW_HS_MODE_LO] =
                    ser_hs_mode_ff;
                nxt_wb_dat[`TASW_HS_SEL_HI:`TASW_HS_SEL_LO] =
                    ser_hs_sel_ff;
            end else if (wb_adr_i == `TASW_OFS_AUX_MODE) begin
                nxt_wb_dat[`TASW_AUX_MODE_HI:`TASW_AUX_MODE_LO] =
                    ser_aux_mode_ff;
                nxt_wb_dat[`TASW_AUX_SEL_HI:`TASW_AUX_SEL_LO] =
                    ser_aux_sel_ff;
            end else if (wb_adr_i == `TASW_OFS_STATUS) begin
                // Status shows the settings in force
                nxt_wb_dat[`TASW_ST_SERIAL_BIT] = serial_ff;
                nxt_wb_dat[`TASW_ST_TERM_BIT] = drive_ff.term_on;
                nxt_wb_dat[`TASW_ST_CUR_BIT] = drive_ff.current_hi;
                nxt_wb_dat[`TASW_ST_EN_BIT] = drive_ff.enable;
                nxt_wb_dat[`TASW_ST_BOOST_HI:`TASW_ST_BOOST_LO] =
                    drive_ff.boost;
            end else begin
                // Unmapped offsets read as zero
                nxt_wb_dat = 32'h0;
            end
        end
    end

    // Bus registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_ff <= 1'h0;
            wb_dat_ff <= 32'h0;
        end else begin
            wb_ack_ff <= nxt_wb_ack;
            wb_dat_ff <= nxt_wb_dat;
        end
    end

    // Serial settings: strap capture, lockout and register writes
    always_comb begin
        nxt_serial = serial_ff || req;
        nxt_strap_done = 1'h1;
        nxt_ser_term = ser_term_ff;
        nxt_ser_cur = ser_cur_ff;
        nxt_ser_boost = ser_boost_ff;
        nxt_ser_en = ser_en_ff;
        nxt_ser_hs_mode = ser_hs_mode_ff;
        nxt_ser_hs_sel = ser_hs_sel_ff;
        nxt_ser_aux_mode = ser_aux_mode_ff;
        nxt_ser_aux_sel = ser_aux_sel_ff;
        if (!strap_done_ff) begin
            // First cycle after reset takes the pin levels
            nxt_ser_term = par_out_term_pin_i;
            nxt_ser_cur = par_current_level_pin_i;
        end else if (wr_take) begin
            if (wb_adr_i == `TASW_OFS_TX_CFG) begin
                nxt_ser_term = wb_dat_i[`TASW_TX_TERM_BIT];
                nxt_ser_cur = wb_dat_i[`TASW_TX_CUR_BIT];
                nxt_ser_boost =
                    wb_dat_i[`TASW_TX_BOOST_HI:`TASW_TX_BOOST_LO];
            end else if (wb_adr_i == `TASW_OFS_HS_MODE) begin
                nxt_ser_en = wb_dat_i[`TASW_HS_ON_BIT];
                // Dual and single reachable only from here
                nxt_ser_hs_mode = tasw_pkg::tasw_mode_t'(
                    wb_dat_i[`TASW_HS_MODE_HI:`TASW_HS_MODE_LO]);
                nxt_ser_hs_sel = wb_dat_i[`TASW_HS_SEL_HI:`TASW_HS_SEL_LO];
            end else if (wb_adr_i == `TASW_OFS_AUX_MODE) begin
                nxt_ser_aux_mode = tasw_pkg::tasw_mode_t'(
                    wb_dat_i[`TASW_AUX_MODE_HI:`TASW_AUX_MODE_LO]);
                nxt_ser_aux_sel =
                    wb_dat_i[`TASW_AUX_SEL_HI:`TASW_AUX_SEL_LO];
            end
        end
    end

    // Serial settings registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_ff <= 1'h0;
            strap_done_ff <= 1'h0;
            ser_term_ff <= 1'h0;
            ser_cur_ff <= 1'h0;
            ser_boost_ff <= `TASW_RST_BOOST;
            ser_en_ff <= `TASW_RST_EN;
            ser_hs_mode_ff <= tasw_pkg::TASW_QUAD;
            ser_hs_sel_ff <= `TASW_RST_SEL;
            ser_aux_mode_ff <= tasw_pkg::TASW_QUAD;
            ser_aux_sel_ff <= `TASW_RST_SEL;
        end else begin
            serial_ff <= nxt_serial;
            strap_done_ff <= nxt_strap_done;
            ser_term_ff <= nxt_ser_term;
            ser_cur_ff <= nxt_ser_cur;
            ser_boost_ff <= nxt_ser_boost;
            ser_en_ff <= nxt_ser_en;
            ser_hs_mode_ff <= nxt_ser_hs_mode;
            ser_hs_sel_ff <= nxt_ser_hs_sel;
            ser_aux_mode_ff <= nxt_ser_aux_mode;
            ser_aux_sel_ff <= nxt_ser_aux_sel;
        end
    end

    // Settings in force: pins until serial takes over
    always_comb begin
        if (serial_ff) begin
            nxt_drive.term_on = ser_term_ff;
            nxt_drive.enable = ser_en_ff;
            nxt_drive.current_hi = ser_cur_ff;
            nxt_drive.boost = ser_boost_ff;
            nxt_hs_route = route_of(ser_hs_mode_ff, ser_hs_sel_ff);
            nxt_aux_route = route_of(ser_aux_mode_ff, ser_aux_sel_ff);
        end else begin
            nxt_drive.term_on = par_out_term_pin_i;
            nxt_drive.enable = par_out_enable_pin_i;
            nxt_drive.current_hi = par_current_level_pin_i;
            nxt_drive.boost = par_boost_bus_i;
            // One select bus, quad only, both switches together
            nxt_hs_route = route_of(tasw_pkg::TASW_QUAD,
                {2'h0, par_channel_select_bus_i});
            nxt_aux_route = nxt_hs_route;
        end
    end

    // Output registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drive_ff <= '0;
            hs_route_ff <= '0;
            aux_route_ff <= '0;
        end else begin
            drive_ff <= nxt_drive;
            hs_route_ff <= nxt_hs_route;
            aux_route_ff <= nxt_aux_route;
        end
    end

    assign wb_ack_o = wb_ack_ff;
    assign wb_dat_o = wb_dat_ff;
    assign drive_o = drive_ff;
    assign hs_route_o = hs_route_ff;
    assign aux_route_o = aux_route_ff;
    assign serial_o = serial_ff;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_serial_take: assert property (
        (wb_cyc_i && wb_stb_i) |=> serial_o)
        else $error("bus access did not lock out the pins");
    a_serial_sticky: assert property (serial_o |=> serial_o)
        else $error("serial lockout released before reset");
    // Sampled reset in the antecedent skips the release edge itself,
    // where the registers still hold their reset values
    a_par_term: assert property (!rst_i && !serial_ff |=>
        drive_o.term_on == $past(par_out_term_pin_i))
        else $error("termination does not follow its pin");
    a_par_enable: assert property (!rst_i && !serial_ff |=>
        drive_o.enable == $past(par_out_enable_pin_i))
        else $error("enable does not follow its pin");
    a_par_boost: assert property (!rst_i && !serial_ff |=>
        drive_o.boost == $past(par_boost_bus_i))
        else $error("boost does not follow its pins");
    a_par_shared: assert property (!rst_i && !serial_ff |=>
        aux_route_o == hs_route_o &&
        hs_route_o.ch3 == {$past(par_channel_select_bus_i), 2'h3})
        else $error("parallel select not shared");
    a_strap_load: assert property (!rst_i && !strap_done_ff |=>
        ser_term_ff == $past(par_out_term_pin_i) &&
        ser_cur_ff == $past(par_current_level_pin_i))
        else $error("pin levels not taken after reset");
    a_single_route: assert property (
        serial_ff && ser_hs_mode_ff == tasw_pkg::TASW_SINGLE |=>
        hs_route_o.ch0 == $past(ser_hs_sel_ff) &&
        hs_route_o.ch3 == hs_route_o.ch0)
        else $error("single mode not routed to all outputs");
    a_dual_route: assert property (
        serial_ff && ser_hs_mode_ff == tasw_pkg::TASW_DUAL |=>
        {1'h0, hs_route_o.ch0[3:1]} == ($past(ser_hs_sel_ff) & 4'h7) &&
        hs_route_o.ch0[0] == 1'h0 && hs_route_o.ch1 == hs_route_o.ch0 &&
        hs_route_o.ch2 == (hs_route_o.ch0 | 4'h1) &&
        hs_route_o.ch3 == hs_route_o.ch2)
        else $error("dual mode switches not locked together");
    a_ser_term: assert property (serial_ff ##1 serial_ff |->
        drive_o.term_on == $past(ser_term_ff))
        else $error("termination ignores serial setting");

endmodule

`default_nettype wire

/* dv/tasw_host.sv */
`timescale 1ns/10ps
`default_nettype none

// Host side of the parallel pins; picks a safe driver setup for the board
module tasw_host (
    // Board setup and wishes of the host
    input wire logic ext_term_i,
    input wire logic int_term_i,
    input wire logic want_en_i,
    input wire logic [1:0] boost_i,
    input wire logic [1:0] sel_i,
    // Parallel control pins
    output logic term_o,
    output logic en_o,
    output logic cur_o,
    output logic [1:0] boost_o,
    output logic [1:0] sel_o
);
    // Termination pin follows the wish directly
    assign term_o = int_term_i;
    // High current only with both terminations fitted
    assign cur_o = int_term_i & ext_term_i;
    // Never enable the outputs with no termination at all
    assign en_o = want_en_i & (int_term_i | ext_term_i);
    // Boost and select pass straight to the pins
    assign boost_o = boost_i;
    assign sel_o = sel_i;
endmodule

`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    // Clock, reset and bus master state
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cyc_r = 1'h0;
    logic we_r = 1'h0;
    logic [7:0] adr_r = 8'h00;
    logic [31:0] dat_r = 32'h0;
    logic [3:0] sel_r = 4'h0;
    // Host wishes and pins
    logic ext_r = 1'h1;
    logic it_r = 1'h1;
    logic wen_r = 1'h1;
    logic [1:0] pb_r = 2'h0;
    logic [1:0] ps_r = 2'h0;
    logic p_term, p_en, p_cur;
    logic [1:0] p_boost, p_sel;
    // Design outputs
    logic [31:0] wb_dat_o;
    logic wb_ack_o, serial_o;
    tasw_pkg::tasw_drive_t drive_o;
    tasw_pkg::tasw_route_t hs_route_o, aux_route_o;
    // Expectations and bookkeeping
    logic [31:0] rd_q[$];
    logic [37:0] out_q[$];
    logic look_r = 1'h0;
    logic [4:0] e_drv;
    logic [15:0] e_hs, e_aux;
    logic e_ser;
    logic [31:0] s_r = 32'h72AB;
    int errors = 0;
    int total_checks = 0;
    int cyc_n = 0;

    tasw_host host (.ext_term_i(ext_r), .int_term_i(it_r),
        .want_en_i(wen_r), .boost_i(pb_r), .sel_i(ps_r), .term_o(p_term),
        .en_o(p_en), .cur_o(p_cur), .boost_o(p_boost), .sel_o(p_sel));

    tasw_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc_r),
        .wb_stb_i(cyc_r), .wb_we_i(we_r), .wb_adr_i(adr_r),
        .wb_sel_i(sel_r), .wb_dat_i(dat_r), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .par_out_term_pin_i(p_term),
        .par_out_enable_pin_i(p_en), .par_current_level_pin_i(p_cur),
        .par_boost_bus_i(p_boost), .par_channel_select_bus_i(p_sel),
        .drive_o(drive_o), .hs_route_o(hs_route_o),
        .aux_route_o(aux_route_o), .serial_o(serial_o));

    // Free running 20 MHz clock
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    // Pseudo random source
    function automatic logic [31:0] xs();
        s_r = s_r ^ (s_r << 13);
        s_r = s_r ^ (s_r >> 17);
        s_r = s_r ^ (s_r << 5);
        return s_r;
    endfunction

    // Binary route of the four outputs for a mode and select
    function automatic logic [15:0] rte(input logic [1:0] m,
                                        input logic [3:0] s);
        case (m)
            2'h1: rte = {s[2:0], 1'h1, s[2:0], 1'h1,
                         s[2:0], 1'h0, s[2:0], 1'h0};
            2'h2: rte = {4{s}};
            default: rte = {s[1:0], 2'h3, s[1:0], 2'h2,
                            s[1:0], 2'h1, s[1:0], 2'h0};
        endcase
    endfunction

    // Compare and count
    task automatic check(input string nm, input logic [37:0] seen,
                         input logic [37:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // Counts, verdict and end of run
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Classic single cycle; held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d, input logic [3:0] s,
                       input logic [7:0] e);
        int n;
        n = 0;
        if (!w) rd_q.push_back({24'h0, e});
        @(posedge clk_i);
        cyc_r <= 1'h1;
        we_r <= w;
        adr_r <= a;
        dat_r <= {24'h0, d};
        sel_r <= s;
        @(posedge clk_i);
        while (wb_ack_o !== 1'h1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 50) errors++;
        cyc_r <= 1'h0;
    endtask

    // Note the expected outputs and ask the monitor to compare them
    task automatic look();
        repeat (3) @(posedge clk_i);
        out_q.push_back({e_drv, e_hs, e_aux, e_ser});
        look_r <= 1'h1;
        @(posedge clk_i);
        look_r <= 1'h0;
    endtask

    // Reset for 20 cycles, then let the pins settle
    task automatic do_reset();
        rst_i <= 1'h1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (3) @(posedge clk_i);
    endtask

    // Monitor: oldest note against each result that appears
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'h1 && we_r === 1'h0) begin
            check("rdata", {6'h0, wb_dat_o},
                  {6'h0, rd_q.pop_front()});
        end
        if (look_r) begin
            check("outs", {drive_o, hs_route_o, aux_route_o, serial_o},
                  out_q.pop_front());
        end
    end

    // Hang guard
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            errors++;
            stop_test();
        end
    end

    // Main sequence
    initial begin
        logic [31:0] r;
        logic [1:0] am;
        logic en;
        do_reset();
        // Parallel control: pins steer drive and both routes
        for (int i = 0; i < 8; i++) begin
            r = xs();
            ext_r <= r[0];
            it_r <= r[1];
            wen_r <= i[2];
            pb_r <= r[4:3];
            ps_r <= i[1:0];
            e_drv = {r[1], i[2] & (r[1] | r[0]), r[1] & r[0], r[4:3]};
            e_hs = rte(2'h0, {2'h0, i[1:0]});
            e_aux = e_hs;
            e_ser = 1'h0;
            look();
        end
        // Pins captured at reset, then a bus access locks them out
        it_r <= 1'h1;
        ext_r <= 1'h0;
        do_reset();
        bus(1'h1, 8'h04, 8'h51, 4'hF, 8'h00);
        bus(1'h0, 8'h0C, 8'h00, 4'hF, 8'h0B);
        e_drv = {1'h1, 1'h1, 1'h0, 2'h0};
        e_hs = rte(2'h0, 4'h5);
        e_aux = rte(2'h0, 4'h0);
        e_ser = 1'h1;
        look();
        it_r <= 1'h0;
        ps_r <= 2'h3;
        pb_r <= 2'h3;
        look();
        // Serial routing modes, auxiliary mode set apart
        for (int m = 0; m < 4; m++) begin
            r = xs();
            am = (m == 2) ? 2'h0 : ((m == 1) ? 2'h2 : 2'h1);
            en = (m != 1);
            bus(1'h1, 8'h04, {r[7:4], 1'h0, m[1:0], en}, 4'hF, 8'h00);
            bus(1'h1, 8'h08, {r[11:8], 2'h0, am}, 4'hF, 8'h00);
            e_drv[3] = en;
            e_hs = rte(m[1:0], r[7:4]);
            e_aux = rte(am, r[11:8]);
            look();
            // Mode fields read back as written, the spare code too
            bus(1'h0, 8'h04, 8'h00, 4'hF, {r[7:4], 1'h0, m[1:0], en});
            bus(1'h0, 8'h08, 8'h00, 4'hF, {r[11:8], 2'h0, am});
        end
        // Serial driver settings and status readback
        for (int b = 0; b < 4; b++) begin
            bus(1'h1, 8'h00, {4'h0, b[1:0], b[0], b[1]}, 4'hF, 8'h00);
            e_drv = {b[1], 1'h1, b[0], b[1:0]};
            look();
            bus(1'h0, 8'h00, 8'h00, 4'hF, {4'h0, b[1:0], b[0], b[1]});
            bus(1'h0, 8'h0C, 8'h00, 4'hF,
                {2'h0, b[1:0], 1'h1, b[0], b[1], 1'h1});
        end
        // Refused writes and an unmapped read
        bus(1'h1, 8'h0C, 8'hFF, 4'hF, 8'h00);
        // Would clear termination, current level and boost if the lane were not refused
        bus(1'h1, 8'h00, 8'h00, 4'hE, 8'h00);
        bus(1'h0, 8'h10, 8'h00, 4'hF, 8'h00);
        bus(1'h0, 8'h0C, 8'h00, 4'hF, 8'h3F);
        look();
        // A new reset hands control back to the pins
        it_r <= 1'h1;
        ext_r <= 1'h1;
        pb_r <= 2'h2;
        ps_r <= 2'h2;
        do_reset();
        e_drv = {1'h1, 1'h1, 1'h1, 2'h2};
        e_hs = rte(2'h0, 4'h2);
        e_aux = e_hs;
        e_ser = 1'h0;
        look();
        repeat (4) @(posedge clk_i);
        stop_test();
    end
endmodule

`default_nettype wire
